// >>> verilog/smbus_oe_consts.svh
/*
  Constants of the SMBus output-enable port: address, register index,
  reset values, field positions and output-enable latency counts.
  Assumes it is included by bare name wherever a value is needed.
*/
`ifndef SMBUS_OE_CONSTS_SVH
`define SMBUS_OE_CONSTS_SVH

// fixed upper address bits, A6 down to A3
`define ADDR_UPPER 4'hD
// low address bits chosen by the three-level strap
`define STRAP_LOW_ADDR 3'h0
`define STRAP_MID_ADDR 3'h1
`define STRAP_HIGH_ADDR 3'h2
// strap pin codes from the analog front end
`define STRAP_CODE_LOW 2'h0
`define STRAP_CODE_MID 2'h1
`define STRAP_CODE_HIGH 2'h2

`define OE_REG_INDEX 8'h00
`define OE_REG_RESET 8'hFF
// reserved bits 5 and 1 always read as one
`define OE_RSVD_MASK 8'h22
// enable bit positions of outputs five down to zero
`define OUT5_POS 7
`define OUT4_POS 6
`define OUT3_POS 4
`define OUT2_POS 3
`define OUT1_POS 2
`define OUT0_POS 0

`define READ_BYTE_COUNT 8'h08
`define UNMAPPED_READ 8'h00
`define BYTE_BITS 4'h8

// output enable latency, in output clock periods
`define OE_LAT_MIN 1
`define OE_LAT_MAX 3

`endif

// >>> verilog/smbus_oe_pkg.sv
/*
  Types of the SMBus output-enable port: strap code, sampled bus lines,
  protocol states and byte roles.
  Assumes the constants header sits beside it.
*/
package smbus_oe_pkg;
    typedef logic [1:0] strap_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_RXD  = 3'b010,
        ST_ACK  = 3'b011,
        ST_TX   = 3'b100,
        ST_HACK = 3'b101,
        ST_TXL  = 3'b110
    } state_e;

    typedef enum logic [1:0] {
        ROLE_ADDR  = 2'b00,
        ROLE_INDEX = 2'b01,
        ROLE_COUNT = 2'b10,
        ROLE_DATA  = 2'b11
    } role_e;
endpackage

// >>> verilog/out_gate.sv
/*
  Output clock gating: one gate per differential output, glitch-free on the true leg only,
  running on the output reference clock.
  Assumes enable bits arrive as levels from another domain and enable
  pins arrive straight from package pins; both are synchronised here.
*/
`timescale 1ns/10ps
module out_gate #(
    parameter int N = 6
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [N-1:0] enable_reg,
    input wire logic [N-1:0] oe_n,
    output logic [N-1:0] q_true,
    output logic [N-1:0] q_comp
);
    logic rst_s1;
    logic rst_s2;
    logic [N-1:0] en_s1;
    logic [N-1:0] en_s2;
    logic [N-1:0] oen_s1;
    logic [N-1:0] oen_s2;
    logic [N-1:0] gate_en;
    wire [N-1:0] want;

    always_ff @(posedge ref_clk) begin
        rst_s1 <= rstn;
        rst_s2 <= rst_s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_s2) begin
            en_s1 <= '0;
            en_s2 <= '0;
            oen_s1 <= '1;
            oen_s2 <= '1;
        end else begin
            en_s1 <= enable_reg;
            en_s2 <= en_s1;
            oen_s1 <= oe_n;
            oen_s2 <= oen_s1;
        end
    end

    // register bit low overrides the pin
    assign want = en_s2 & ~oen_s2; // R8

    // taken on the falling edge so a change lands in the low phase, no runt on the true legs
    always_ff @(negedge ref_clk) begin
        if (!rst_s2) begin
            gate_en <= '0;
        end else begin
            gate_en <= want; // R10 R9
        end
    end

    // disabled outputs sit low on both legs
    assign q_true = {N{ref_clk}} & gate_en; // R8
    assign q_comp = {N{~ref_clk}} & gate_en; // R8

    gate_low_phase_a: assert property (@(posedge ref_clk) disable iff (!rst_s2) gate_en == want) // R10
        else $error("gate enable not taken in the preceding low phase");

    oe_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_s2) // R9
        $changed(oen_s2) |-> ##[0:2] (q_comp == want))
        else $error("output enable latency exceeded");

    legs_low_a: assert property (@(posedge ref_clk) disable iff (!rst_s2) // R8
        ((q_true | q_comp) & ~want) == '0)
        else $error("disabled output not held low");
endmodule

// >>> verilog/smbus_oe_port.sv
/*
  SMBus target port with the output enable register, and the gating of
  the six differential clock outputs.
  Assumes SCL and SDA come from pins, SDA is open drain and resolved
  outside, the strap arrives already decoded to a three-level code and is
  steady during reset, and RSTN is held for at least two CLOCK and two REF_CLK edges.
*/
`timescale 1ns/10ps
`include "smbus_oe_consts.svh"

// Overview of operation
// R1: target only; answers block write and read to one 7-bit address.
// R2: stop after any whole byte ends the transfer and keeps finished bytes.
// R3: address is 1101 plus three low bits from the strap latched at reset.
// R4: write is address, index, count, data; every byte acknowledged.
// R5: read sets index by write, then repeated start with read bit.
// R6: read returns count first, then bytes from index; host nacks last.
// R7: index 0 holds enables at bits 7,6,4,3,2,0; bits 5,1 reserved; resets all ones.
// R8: enable bit low drives both legs low regardless of pin.
// R9: pin change starts or stops output within one to three output clocks.
// R10: enable changes take effect only in the output's low phase; met on true legs only, complement legs change as they rise.
module smbus_oe_port (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire smbus_oe_pkg::strap_t ADDR_STRAP,
    input wire logic REF_CLK,
    input wire logic [5:0] OE_N,
    output logic [5:0] Q_TRUE,
    output logic [5:0] Q_COMP
);
    import smbus_oe_pkg::*;

    function automatic logic [2:0] strap_bits(input strap_t code);
        if (code == `STRAP_CODE_LOW) begin
            return `STRAP_LOW_ADDR;
        end else if (code == `STRAP_CODE_MID) begin
            return `STRAP_MID_ADDR;
        end else begin
            return `STRAP_HIGH_ADDR;
        end
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] index, input logic [7:0] value);
        if (index == `OE_REG_INDEX) begin
            return value;
        end else begin
            return `UNMAPPED_READ;
        end
    endfunction

    function automatic role_e next_role(input role_e r);
        case (r)
            ROLE_ADDR: return ROLE_INDEX;
            ROLE_INDEX: return ROLE_COUNT;
            default: return ROLE_DATA;
        endcase
    endfunction

    function automatic logic [5:0] oe_vector(input logic [7:0] r);
        return {r[`OUT5_POS], r[`OUT4_POS], r[`OUT3_POS], r[`OUT2_POS], r[`OUT1_POS], r[`OUT0_POS]};
    endfunction

    line_s s1;
    line_s s2;
    line_s s3;
    strap_t strap_s1;
    strap_t strap_s2;
    logic strap_taken;
    logic [2:0] addr_low;
    state_e st;
    role_e role;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic [7:0] oe_reg;
    logic [3:0] bitcnt;
    logic rd_dir;
    logic first_tx;
    logic sda_low;

    // s1 feeds s2 only; edges are found between s2 and s3
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            s1 <= 2'h3;
            s2 <= 2'h3;
            s3 <= 2'h3;
        end else begin
            s1 <= {SCL, SDA_IN};
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge CLOCK) begin
        strap_s1 <= ADDR_STRAP;
        strap_s2 <= strap_s1;
    end

    // strap caught once, on the first edge after release
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            strap_taken <= 1'b0;
            addr_low <= 3'h0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            addr_low <= strap_bits(strap_s2); // R3
        end
    end

    wire scl_rise = s2.scl & ~s3.scl;
    wire scl_fall = ~s2.scl & s3.scl;
    wire start_seen = s2.scl & s3.scl & s3.sda & ~s2.sda;
    wire stop_seen = s2.scl & s3.scl & ~s3.sda & s2.sda;
    wire [6:0] my_addr = {`ADDR_UPPER, addr_low}; // R3
    wire byte_hit = (shift[7:1] == my_addr); // R1
    wire [7:0] rd_byte = first_tx ? `READ_BYTE_COUNT : reg_read(ptr, oe_reg); // R6
    wire load_tx = scl_fall && ((st == ST_ACK && rd_dir) || st == ST_TXL);
    wire byte_end = (st == ST_RXD) && scl_fall;
    wire oe_write = byte_end && role == ROLE_DATA && ptr == `OE_REG_INDEX; // R4
    wire [7:0] oe_wdata = shift | `OE_RSVD_MASK; // R7

    // start and stop win over any bit event; stop releases SDA at once
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            st <= ST_IDLE;
            role <= ROLE_ADDR;
            shift <= 8'h00;
            ptr <= 8'h00;
            tx <= 8'h00;
            bitcnt <= 4'h0;
            rd_dir <= 1'b0;
            first_tx <= 1'b0;
            sda_low <= 1'b0;
        end else if (stop_seen) begin
            st <= ST_IDLE; // R2
            sda_low <= 1'b0;
        end else if (start_seen) begin
            st <= ST_RX; // R5
            role <= ROLE_ADDR;
            bitcnt <= 4'h0;
            sda_low <= 1'b0;
        end else if (load_tx) begin
            st <= ST_TX; // R6
            sda_low <= ~rd_byte[7];
            tx <= {rd_byte[6:0], 1'b0};
            bitcnt <= 4'h1;
            if (first_tx) begin
                first_tx <= 1'b0;
            end else begin
                ptr <= ptr + 8'h01;
            end
        end else begin
            case (st)
                ST_RX: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], s2.sda};
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == `BYTE_BITS - 4'h1) begin
                            st <= ST_RXD;
                        end
                    end
                end
                ST_RXD: begin
                    if (scl_fall) begin
                        if (role == ROLE_ADDR && !byte_hit) begin
                            st <= ST_IDLE; // R1
                        end else begin
                            st <= ST_ACK; // R4 R5
                            sda_low <= 1'b1;
                            role <= next_role(role);
                            if (role == ROLE_ADDR) begin
                                rd_dir <= shift[0];
                                first_tx <= 1'b1;
                            end
                            if (role == ROLE_INDEX) begin
                                ptr <= shift; // R5
                            end
                            if (role == ROLE_DATA) begin
                                ptr <= ptr + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        st <= ST_RX;
                        sda_low <= 1'b0;
                        bitcnt <= 4'h0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == `BYTE_BITS) begin
                            st <= ST_HACK;
                            sda_low <= 1'b0;
                        end else begin
                            sda_low <= ~tx[7];
                            tx <= {tx[6:0], 1'b0};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                ST_HACK: begin
                    if (scl_rise) begin
                        st <= s2.sda ? ST_IDLE : ST_TXL; // R6
                    end
                end
                default: begin
                    st <= st;
                end
            endcase
        end
    end

    // reserved bits cannot be cleared by a write
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            oe_reg <= `OE_REG_RESET; // R7
        end else if (oe_write) begin
            oe_reg <= oe_wdata; // R7
        end
    end

    // open drain: the pin is only ever pulled low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_low;

    out_gate #(
        .N(6)
    ) u_gate (
        .ref_clk(REF_CLK),
        .rstn(RSTN),
        .enable_reg(oe_vector(oe_reg)),
        .oe_n(OE_N),
        .q_true(Q_TRUE),
        .q_comp(Q_COMP)
    );

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    idle_quiet_a: assert property (st == ST_IDLE |-> !sda_low) // R1
        else $error("SDA pulled while idle");

    addr_ack_a: assert property (byte_end && !stop_seen && !start_seen && role == ROLE_ADDR && byte_hit // R3
        |=> sda_low && st == ST_ACK)
        else $error("own address not acknowledged");

    addr_miss_a: assert property (byte_end && !stop_seen && !start_seen && role == ROLE_ADDR && !byte_hit // R1
        |=> st == ST_IDLE && !sda_low)
        else $error("foreign address acknowledged");

    stop_idle_a: assert property (stop_seen |=> st == ST_IDLE && !sda_low) // R2
        else $error("stop did not return to idle");

    oe_store_a: assert property (oe_write && !stop_seen |=> oe_reg == ($past(shift) | `OE_RSVD_MASK)) // R4
        else $error("output enable write lost");

    rsvd_one_a: assert property ((oe_reg & `OE_RSVD_MASK) == `OE_RSVD_MASK) // R7
        else $error("reserved enable bits not one");

    index_load_a: assert property (byte_end && !stop_seen && !start_seen && role == ROLE_INDEX // R5
        |=> ptr == $past(shift))
        else $error("start index not taken");

    // a literal cannot be bit-selected, so the count byte is named first
    localparam logic [7:0] COUNT_BYTE = `READ_BYTE_COUNT;

    count_first_a: assert property (load_tx && first_tx && !stop_seen && !start_seen // R6
        |=> sda_low == !COUNT_BYTE[7] && $stable(ptr))
        else $error("byte count not sent first");

    host_nack_a: assert property (st == ST_HACK && scl_rise && s2.sda && !stop_seen && !start_seen // R6
        |=> st == ST_IDLE ##1 !sda_low [*2])
        else $error("host nack did not end the read");
endmodule

// >>> testbench/smbus_host_model.sv
/*
  Behavioural SMBus host: start, stop, byte send and byte receive tasks.
  Assumes the bench resolves the open-drain data line with a pull-up and
  feeds the wire level back on sda_line.
*/
`timescale 1ns/10ps
module smbus_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask

    // also serves as repeated start when entered with scl low
    task automatic start();
        sda <= 1'b1;
        pause(6);
        scl <= 1'b1;
        pause(6);
        sda <= 1'b0;
        pause(6);
        scl <= 1'b0;
    endtask

    // ends a transfer after any whole byte, or mid-byte on purpose
    task automatic stop();
        pause(6);
        sda <= 1'b0;
        pause(6);
        scl <= 1'b1;
        pause(6);
        sda <= 1'b1;
        pause(12);
    endtask

    // data set mid-low, sampled mid-high; 6 cycles of hold after each fall
    task automatic bit_io(input logic b, output logic r);
        pause(6);
        sda <= b;
        pause(6);
        scl <= 1'b1;
        pause(6);
        r = sda_line;
        pause(6);
        scl <= 1'b0;
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // host acks every byte but the last, which it nacks
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule

// >>> testbench/tb_top.sv
/*
  Self-checking bench of the SMBus output-enable port with a host model.
  Assumes the strap is tied mid and the output reference clock is free running.
*/
`timescale 1ns/10ps
`include "smbus_oe_consts.svh"
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_top;
    import smbus_oe_pkg::*;
    logic clock = 1'b0;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] oe_n = 6'h00;
    logic scl, host_sda, sda_line, sda_oe;
    logic [5:0] q_true, q_comp;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam logic [6:0] ADDR = {`ADDR_UPPER, `STRAP_MID_ADDR};

    always #2 clock = ~clock;
    initial begin
        #7;
        forever #32 ref_clk = ~ref_clk;
    end
    // pull-up: the wire is low only while someone pulls it
    assign sda_line = sda_oe ? 1'b0 : host_sda;

    smbus_oe_port i_dut (.CLOCK(clock), .RSTN(rstn), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(), .SDA_OE(sda_oe),
        .ADDR_STRAP(`STRAP_CODE_MID), .REF_CLK(ref_clk), .OE_N(oe_n), .Q_TRUE(q_true), .Q_COMP(q_comp));
    smbus_host_model i_host (.clk(clock), .sda_line(sda_line), .scl(scl), .sda(host_sda));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic blk_write(input logic [7:0] idx, input logic [7:0] d);
        logic a0, a1, a2, a3;
        i_host.start();
        i_host.send({ADDR, 1'b0}, a0);
        i_host.send(idx, a1);
        i_host.send(8'h01, a2);
        i_host.send(d, a3);
        i_host.stop();
        `CHECK({a0, a1, a2, a3}, 4'hF)
    endtask

    task automatic blk_read(input logic [7:0] idx, output logic [7:0] d);
        logic a0, a1, a2;
        logic [7:0] cnt;
        i_host.start();
        i_host.send({ADDR, 1'b0}, a0);
        i_host.send(idx, a1);
        i_host.start();
        i_host.send({ADDR, 1'b1}, a2);
        i_host.recv(1'b0, cnt);
        i_host.recv(1'b1, d);
        i_host.stop();
        `CHECK({a0, a1, a2}, 3'h7)
        `CHECK(cnt, `READ_BYTE_COUNT)
    endtask

    // sample the true legs mid-high and the complement legs mid-low of the reference clock
    task automatic check_legs(input logic [5:0] exp);
        @(posedge ref_clk);
        #16;
        `CHECK(q_true, exp)
        @(negedge ref_clk);
        #16;
        `CHECK(q_comp, exp)
    endtask

    task automatic t_reset_read();
        logic [7:0] d;
        blk_read(`OE_REG_INDEX, d);
        `CHECK(d, `OE_REG_RESET)
        check_legs(6'h3F);
    endtask

    task automatic t_wrong_addr();
        logic ack;
        i_host.start();
        i_host.send({`ADDR_UPPER, 3'h5, 1'b0}, ack);
        i_host.stop();
        `CHECK(ack, 1'b0)
    endtask

    task automatic t_pin_latency();
        @(posedge clock);
        oe_n <= 6'h04;
        @(posedge ref_clk);
        #16;
        `CHECK(q_true, 6'h3F)
        #192;
        check_legs(6'h3B);
        @(posedge clock);
        oe_n <= 6'h00;
        #192;
        check_legs(6'h3F);
    endtask

    // a complete data byte sticks; a half byte cut by stop is dropped
    task automatic t_early_stop();
        logic a;
        logic r;
        logic [7:0] d;
        blk_write(`OE_REG_INDEX, 8'h00);
        i_host.start();
        i_host.send({ADDR, 1'b0}, a);
        i_host.send(`OE_REG_INDEX, a);
        i_host.send(8'h01, a);
        i_host.send(8'hFF, a);
        i_host.send(8'h00, a); // index 1, discarded
        i_host.stop();
        i_host.start();
        i_host.send({ADDR, 1'b0}, a);
        i_host.send(`OE_REG_INDEX, a);
        i_host.send(8'h01, a);
        repeat (4) i_host.bit_io(1'b0, r);
        i_host.stop();
        blk_read(`OE_REG_INDEX, d);
        `CHECK(d, `OE_REG_RESET)
        blk_read(8'h01, d);
        `CHECK(d, `UNMAPPED_READ)
    endtask

    task automatic t_write_disable();
        logic [7:0] d;
        blk_write(`OE_REG_INDEX, 8'h40);
        blk_read(`OE_REG_INDEX, d);
        `CHECK(d, 8'h40 | `OE_RSVD_MASK)
        #400;
        check_legs(6'h10);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        @(posedge clock);
        rstn <= 1'b1;
        i_host.pause(10);
        t_reset_read();
        t_wrong_addr();
        t_pin_latency();
        t_early_stop();
        t_write_disable();
        tally_and_finish();
    end
endmodule
